/* shared/tpzi_pkg.sv */
package tpzi_pkg;
  // register map, 8-bit microprocessor port
  localparam logic [15:0] ADDR_SRC_SEL = 16'h1982;
  localparam logic [15:0] ADDR_Z3_VAL = 16'h19AB;
  localparam logic [15:0] ADDR_Z4_VAL = 16'h19AF;
  localparam int SEL_Z3_BIT = 1;
  localparam int SEL_Z4_BIT = 2;
  localparam logic [7:0] SEL_RW_MASK = 8'h0F;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] VAL_RESET = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // serial overhead clock timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OH_CLK_PERIOD_NS = 120;
  localparam int OH_HALF_CYC_INT = OH_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [3:0] OH_HALF_CYC = OH_HALF_CYC_INT[3:0];
  localparam logic [3:0] OH_DIV_LAST = 4'(2 * OH_HALF_CYC_INT - 1);

  // overhead byte slots, counted in serial clock rising edges from the frame edge
  localparam int BYTE_BITS = 8;
  localparam int Z3_POH_BYTE = 7;
  localparam int Z4_POH_BYTE = 8;
  localparam int POH_BYTES = 9;
  localparam logic [7:0] Z3_WAIT = 8'((Z3_POH_BYTE - 1) * BYTE_BITS);
  localparam logic [7:0] Z4_WAIT = 8'((Z4_POH_BYTE - 1) * BYTE_BITS);
  localparam logic [7:0] Z3_LAST = 8'(Z3_POH_BYTE * BYTE_BITS);
  localparam logic [7:0] Z4_LAST = 8'(Z4_POH_BYTE * BYTE_BITS);
  localparam logic [7:0] POH_SLOT_CLKS = 8'(POH_BYTES * BYTE_BITS);
  localparam logic [7:0] FRAME_OH_CLKS = 8'h60;
  localparam logic [7:0] FRAME_LAST = FRAME_OH_CLKS - 8'h01;
endpackage

/* logic/tpzi_oh_clkgen.sv */
`timescale 1ns/10ps
// divides the system clock into the serial overhead clock and marks its edges
module tpzi_oh_clkgen (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  output logic oh_clk_o,
  output logic rise_o,
  output logic fall_o
);
  logic [3:0] div_cnt;
  logic [3:0] next_div_cnt;
  logic next_clk;
  logic next_rise;
  logic next_fall;

  always_comb begin
    next_div_cnt = (div_cnt == tpzi_pkg::OH_DIV_LAST) ? 4'h0 : div_cnt + 4'h1;
    next_clk = (next_div_cnt < tpzi_pkg::OH_HALF_CYC);
    next_rise = (next_div_cnt == 4'h0);
    next_fall = (next_div_cnt == tpzi_pkg::OH_HALF_CYC);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      div_cnt <= 4'h0;
      oh_clk_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      oh_clk_o <= next_clk;
      rise_o <= next_rise;
      fall_o <= next_fall;
    end
  end
endmodule

/* logic/tpzi_z3z4_insert.sv */
`timescale 1ns/10ps
module tpzi_z3z4_insert (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [15:0] mp_addr_i,
  input wire logic mp_wr_i,
  input wire logic [7:0] mp_wdata_i,
  output logic [7:0] mp_rdata_o,
  input wire logic oh_serial_data_in_i,
  output logic oh_serial_clock_out_o,
  output logic oh_slot_enable_out_o,
  output logic oh_frame_marker_out_o,
  output logic [7:0] z3_outbound_byte_o,
  output logic [7:0] z4_outbound_byte_o
);
  logic oh_rise;
  logic oh_fall;
  logic sdata_meta;
  logic sdata_sync;
  logic [7:0] src_sel;
  logic [7:0] z3_sw_value;
  logic [7:0] z4_sw_value;
  logic [7:0] rise_cnt;
  logic [7:0] z3_shift;
  logic [7:0] z4_shift;
  logic [7:0] z3_serial;
  logic [7:0] z4_serial;
  logic [7:0] next_src_sel;
  logic [7:0] next_z3_sw_value;
  logic [7:0] next_z4_sw_value;
  logic [7:0] next_rdata;
  logic [7:0] next_rise_cnt;
  logic [7:0] next_z3_shift;
  logic [7:0] next_z4_shift;
  logic [7:0] next_z3_serial;
  logic [7:0] next_z4_serial;
  logic [7:0] next_z3_out;
  logic [7:0] next_z4_out;
  logic next_frame;
  logic next_enable;
  logic [7:0] rise_idx;

  tpzi_oh_clkgen u_clkgen (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .oh_clk_o(oh_serial_clock_out_o),
    .rise_o(oh_rise),
    .fall_o(oh_fall)
  );

  // register port
  always_comb begin
    next_src_sel = src_sel;
    next_z3_sw_value = z3_sw_value;
    next_z4_sw_value = z4_sw_value;
    if (mp_wr_i) begin
      unique case (mp_addr_i)
        tpzi_pkg::ADDR_SRC_SEL: next_src_sel = mp_wdata_i & tpzi_pkg::SEL_RW_MASK;
        tpzi_pkg::ADDR_Z3_VAL: next_z3_sw_value = mp_wdata_i;
        tpzi_pkg::ADDR_Z4_VAL: next_z4_sw_value = mp_wdata_i;
        default: next_src_sel = src_sel;
      endcase
    end
    unique case (mp_addr_i)
      tpzi_pkg::ADDR_SRC_SEL: next_rdata = src_sel;
      tpzi_pkg::ADDR_Z3_VAL: next_rdata = z3_sw_value;
      tpzi_pkg::ADDR_Z4_VAL: next_rdata = z4_sw_value;
      default: next_rdata = tpzi_pkg::RDATA_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      src_sel <= tpzi_pkg::SEL_RESET;
      z3_sw_value <= tpzi_pkg::VAL_RESET;
      z4_sw_value <= tpzi_pkg::VAL_RESET;
      mp_rdata_o <= tpzi_pkg::RDATA_UNMAPPED;
    end else begin
      src_sel <= next_src_sel;
      z3_sw_value <= next_z3_sw_value;
      z4_sw_value <= next_z4_sw_value;
      mp_rdata_o <= next_rdata;
    end
  end

  // serial input crosses in through two flops
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sdata_meta <= 1'b0;
      sdata_sync <= 1'b0;
    end else begin
      sdata_meta <= oh_serial_data_in_i;
      sdata_sync <= sdata_meta;
    end
  end

  // frame timeline and capture; rise_cnt holds the index of the last rising edge
  always_comb begin
    rise_idx = (rise_cnt == tpzi_pkg::FRAME_LAST) ? 8'h00 : rise_cnt + 8'h01;
    next_rise_cnt = rise_cnt;
    next_z3_shift = z3_shift;
    next_z4_shift = z4_shift;
    next_z3_serial = z3_serial;
    next_z4_serial = z4_serial;
    next_frame = oh_frame_marker_out_o;
    next_enable = oh_slot_enable_out_o;
    if (oh_rise) begin
      next_rise_cnt = rise_idx;
      if (rise_idx > tpzi_pkg::Z3_WAIT && rise_idx <= tpzi_pkg::Z3_LAST) begin
        next_z3_shift = {z3_shift[6:0], sdata_sync};
      end
      if (rise_idx > tpzi_pkg::Z4_WAIT && rise_idx <= tpzi_pkg::Z4_LAST) begin
        next_z4_shift = {z4_shift[6:0], sdata_sync};
      end
      if (rise_idx == tpzi_pkg::Z3_LAST) begin
        next_z3_serial = {z3_shift[6:0], sdata_sync};
      end
      if (rise_idx == tpzi_pkg::Z4_LAST) begin
        next_z4_serial = {z4_shift[6:0], sdata_sync};
      end
    end
    // marks change on falling edges so the far end sees them stable at rising ones
    if (oh_fall) begin
      next_frame = (rise_cnt == tpzi_pkg::FRAME_LAST);
      next_enable = (rise_cnt == tpzi_pkg::FRAME_LAST) || (rise_cnt < tpzi_pkg::POH_SLOT_CLKS);
    end
    next_z3_out = src_sel[tpzi_pkg::SEL_Z3_BIT] ? z3_serial : z3_sw_value;
    next_z4_out = src_sel[tpzi_pkg::SEL_Z4_BIT] ? z4_serial : z4_sw_value;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rise_cnt <= tpzi_pkg::FRAME_LAST;
      z3_shift <= 8'h00;
      z4_shift <= 8'h00;
      z3_serial <= 8'h00;
      z4_serial <= 8'h00;
      oh_frame_marker_out_o <= 1'b0;
      oh_slot_enable_out_o <= 1'b0;
      z3_outbound_byte_o <= 8'h00;
      z4_outbound_byte_o <= 8'h00;
    end else begin
      rise_cnt <= next_rise_cnt;
      z3_shift <= next_z3_shift;
      z4_shift <= next_z4_shift;
      z3_serial <= next_z3_serial;
      z4_serial <= next_z4_serial;
      oh_frame_marker_out_o <= next_frame;
      oh_slot_enable_out_o <= next_enable;
      z3_outbound_byte_o <= next_z3_out;
      z4_outbound_byte_o <= next_z4_out;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  a_z3_sw_path: assert property (!src_sel[tpzi_pkg::SEL_Z3_BIT]
      |=> z3_outbound_byte_o == $past(z3_sw_value))
    else $error("z3 byte not taken from software value");
  a_z3_reg_write: assert property (mp_wr_i && mp_addr_i == tpzi_pkg::ADDR_Z3_VAL
      |=> z3_sw_value == $past(mp_wdata_i) ##1 mp_rdata_o == $past(mp_wdata_i, 2)
      || mp_addr_i != tpzi_pkg::ADDR_Z3_VAL)
    else $error("z3 value register write lost");
  a_z3_serial_path: assert property (src_sel[tpzi_pkg::SEL_Z3_BIT]
      |=> z3_outbound_byte_o == $past(z3_serial))
    else $error("z3 byte not taken from serial input");
  a_z4_sw_path: assert property (!src_sel[tpzi_pkg::SEL_Z4_BIT]
      |=> z4_outbound_byte_o == $past(z4_sw_value))
    else $error("z4 byte not taken from software value");
  a_z4_serial_path: assert property (src_sel[tpzi_pkg::SEL_Z4_BIT]
      |=> z4_outbound_byte_o == $past(z4_serial))
    else $error("z4 byte not taken from serial input");
  a_z4_reg_write: assert property (mp_wr_i && mp_addr_i == tpzi_pkg::ADDR_Z4_VAL
      |=> z4_sw_value == $past(mp_wdata_i))
    else $error("z4 value register write lost");
  a_z3_capture: assert property (oh_rise && rise_idx == tpzi_pkg::Z3_LAST
      |=> z3_serial == {$past(z3_shift[6:0]), $past(sdata_sync)} && rise_cnt == tpzi_pkg::Z3_LAST)
    else $error("z3 serial byte not latched at edge 56");
  a_z4_capture: assert property (oh_rise && rise_idx == tpzi_pkg::Z4_LAST
      |=> z4_serial == {$past(z4_shift[6:0]), $past(sdata_sync)} && rise_cnt == tpzi_pkg::Z4_LAST)
    else $error("z4 serial byte not latched at edge 64");
  a_frame_mark: assert property (oh_rise && rise_idx == 8'h00
      |-> oh_frame_marker_out_o && oh_slot_enable_out_o ##1 oh_frame_marker_out_o [*5])
    else $error("frame and enable not high around edge zero");
  a_sel_upper_zero: assert property (src_sel[7:4] == 4'h0)
    else $error("unused control bits not zero");
  // the first high phase after reset is short and carries no rise mark, so it is not checked
  a_oh_clk_high: assert property (oh_rise
      |-> oh_serial_clock_out_o [*6] ##1 !oh_serial_clock_out_o)
    else $error("serial clock high phase not six cycles");
  a_oh_clk_low: assert property (oh_fall
      |-> !oh_serial_clock_out_o [*6] ##1 oh_serial_clock_out_o)
    else $error("serial clock low phase not six cycles");
  a_enable_close: assert property (oh_fall && rise_cnt == tpzi_pkg::POH_SLOT_CLKS
      |=> !oh_slot_enable_out_o)
    else $error("overhead enable still high after the slot window");
  a_frame_single: assert property (oh_fall && rise_cnt != tpzi_pkg::FRAME_LAST
      |=> !oh_frame_marker_out_o)
    else $error("frame marker high away from edge zero");
  a_z3_serial_hold: assert property (!(oh_rise && rise_idx == tpzi_pkg::Z3_LAST)
      |=> $stable(z3_serial))
    else $error("z3 serial byte changed outside its capture edge");

  c_z3_serial: cover property (src_sel[tpzi_pkg::SEL_Z3_BIT] && oh_rise
      && rise_idx == tpzi_pkg::Z3_LAST);
  c_z4_serial: cover property (src_sel[tpzi_pkg::SEL_Z4_BIT] && oh_rise
      && rise_idx == tpzi_pkg::Z4_LAST);
  c_frame_start: cover property ($rose(oh_frame_marker_out_o));
  c_sw_both: cover property (!src_sel[tpzi_pkg::SEL_Z3_BIT] && !src_sel[tpzi_pkg::SEL_Z4_BIT]
      && oh_rise && rise_idx == tpzi_pkg::Z4_LAST);
endmodule

/* tb/tpzi_far_end.sv */
`timescale 1ns/10ps
// far-end logic that shifts the z3 and z4 bytes into the serial overhead input
module tpzi_far_end (
  input wire logic oh_clk_i,
  input wire logic enable_i,
  input wire logic frame_i,
  input wire logic [7:0] z3_i,
  input wire logic [7:0] z4_i,
  output logic data_o
);
  int edge_cnt = -1;
  logic [15:0] word = 16'h0000;
  initial data_o = 1'b0;
  // no insert strobe is driven in serial mode
  // counts rising edges from the one that sees enable and frame high
  always @(posedge oh_clk_i) begin
    if (enable_i && frame_i) begin
      edge_cnt <= 0;
      word <= {z3_i, z4_i};
    end else if (edge_cnt >= 0 && edge_cnt < 64) begin
      edge_cnt <= edge_cnt + 1;
    end else begin
      edge_cnt <= -1;
    end
  end
  // msb after 48 clocks, z4 from 56, one bit per falling edge
  always @(negedge oh_clk_i) begin
    if (edge_cnt >= 48 && edge_cnt < 64) begin
      data_o <= word[63 - edge_cnt];
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule

/* tb/tpzi_z3z4_insert_bench.sv */
`timescale 1ns/10ps
module tpzi_z3z4_insert_bench;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] mp_addr_i = 16'h0000;
  logic mp_wr_i = 1'b0;
  logic [7:0] mp_wdata_i = 8'h00;
  logic [7:0] mp_rdata_o, z3_outbound_byte_o, z4_outbound_byte_o;
  logic oh_serial_data_in_i, oh_serial_clock_out_o, oh_slot_enable_out_o, oh_frame_marker_out_o;
  logic [7:0] far_z3 = 8'h00;
  logic [7:0] far_z4 = 8'h00;
  logic [7:0] m_sel, m_z3, m_z4;
  logic [31:0] lfsr = 32'h00017407;
  int failures = 0;
  int total_checks = 0;
  logic [15:0] addrs [4] = '{16'h1982, 16'h19AB, 16'h19AF, 16'h1234};
  logic [7:0] modes [4] = '{8'h00, 8'h06, 8'h0B, 8'h0D};

  always #5 clk_sys_i = ~clk_sys_i;

  tpzi_z3z4_insert dut (.clk_sys_i, .rst_i, .mp_addr_i, .mp_wr_i, .mp_wdata_i, .mp_rdata_o,
    .oh_serial_data_in_i, .oh_serial_clock_out_o, .oh_slot_enable_out_o,
    .oh_frame_marker_out_o, .z3_outbound_byte_o, .z4_outbound_byte_o);

  tpzi_far_end far (.oh_clk_i(oh_serial_clock_out_o), .enable_i(oh_slot_enable_out_o),
    .frame_i(oh_frame_marker_out_o), .z3_i(far_z3), .z4_i(far_z4),
    .data_o(oh_serial_data_in_i));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    mp_addr_i <= a;
    mp_wr_i <= 1'b1;
    mp_wdata_i <= d;
    @(posedge clk_sys_i);
    mp_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys_i);
    mp_addr_i <= a;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  // counts frame marker rises, bounded so a dead link ends the run
  task automatic wait_frames(input int n);
    int k;
    logic prev;
    k = 0;
    prev = oh_frame_marker_out_o;
    for (int c = 0; c < 3000 * n && k < n; c++) begin
      @(posedge clk_sys_i);
      #1;
      if (oh_frame_marker_out_o && !prev) k++;
      prev = oh_frame_marker_out_o;
    end
    if (k < n) begin
      failures++;
      $display("wrong value at %0t: frame marker missing", $time);
      conclude();
    end
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    foreach (addrs[i]) begin
      rd(addrs[i]);
      check(mp_rdata_o, 8'h00, "reset value");
    end
    foreach (modes[i]) begin
      lfsr = lfsr_next(lfsr);
      wr(tpzi_pkg::ADDR_SRC_SEL, {lfsr[7:4], modes[i][3:0]});
      m_sel = modes[i];
      wr(tpzi_pkg::ADDR_Z3_VAL, lfsr[15:8]);
      m_z3 = lfsr[15:8];
      wr(tpzi_pkg::ADDR_Z4_VAL, lfsr[23:16]);
      m_z4 = lfsr[23:16];
      lfsr = lfsr_next(lfsr);
      far_z3 = lfsr[7:0];
      far_z4 = lfsr[15:8];
      rd(tpzi_pkg::ADDR_SRC_SEL);
      check(mp_rdata_o, m_sel, "control");
      rd(tpzi_pkg::ADDR_Z3_VAL);
      check(mp_rdata_o, m_z3, "z3 value");
      rd(tpzi_pkg::ADDR_Z4_VAL);
      check(mp_rdata_o, m_z4, "z4 value");
      wait_frames(2);
      check(z3_outbound_byte_o, m_sel[1] ? far_z3 : m_z3, "z3 byte");
      check(z4_outbound_byte_o, m_sel[2] ? far_z4 : m_z4, "z4 byte");
    end
    wr(16'h1234, lfsr[7:0]);
    rd(16'h1234);
    check(mp_rdata_o, 8'h00, "unmapped");
    rd(tpzi_pkg::ADDR_SRC_SEL);
    check(mp_rdata_o, m_sel, "control kept");
    // second reset in mid-run: registers and outbound bytes fall back to zero
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    foreach (addrs[i]) begin
      rd(addrs[i]);
      check(mp_rdata_o, 8'h00, "value after reset");
    end
    wait_frames(1);
    check(z3_outbound_byte_o, 8'h00, "z3 byte after reset");
    check(z4_outbound_byte_o, 8'h00, "z4 byte after reset");
    conclude();
  end
endmodule
